/* src/clk_div_pkg.sv */
// Purpose: Shared constants for the system clock divider and trim block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets are byte addresses

package clk_div_pkg;
   // Register map
   localparam logic [11:0] TRIM_OFFSET     = 12'h000;
   localparam logic [11:0] DIVCTRL_OFFSET  = 12'h004;
   localparam logic [11:0] DIVSTAT_OFFSET  = 12'h008;
   // Divide control fields
   localparam int          UNLOCK_BIT      = 7;
   localparam int          SEL_LSB         = 0;
   localparam int          SEL_W           = 4;
   localparam int          TRIM_W          = 7;
   // Largest legal select code (factor 256)
   localparam logic [3:0]  SEL_MAX         = 4'h8;
   localparam logic [3:0]  SEL_DIV8        = 4'h3;
   localparam logic [3:0]  SEL_DIV1        = 4'h0;
   // Unlock window, in cycles of the divided clock
   localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
   // Reset values
   localparam logic [6:0]  TRIM_RST        = 7'h40;
   localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;
   // Prescaler synchronous counter width (256 = 2**8)
   localparam int          CNT_W           = 8;
endpackage : clk_div_pkg

/* src/clk_div_trim.sv */
// Purpose: Power-of-two system clock divider with unlock sequence and
//          oscillator trim register, reached over APB
// Assumes: core_clk is the undivided master clock; fuse and factory
//          calibration inputs are static straps from another domain
// Notes:   Divided clock is given as a one-cycle enable, shared by all
//          downstream domains
//
// Timing at a glance
//    APB: setup, then two access cycles; pready is high in the second
//    one. Writes land at the edge where pready is sampled high, so a
//    master that aborts early changes nothing.
//    Straps: fuse and calibration pass two flops that run through
//    reset, so both stages are settled when reset ends and the first
//    edge after release loads them.
//    Unlock: the window lasts four divided-clock enables. A select
//    write with the unlock bit low closes it at once, stored or not.
//    Switch: a new select waits for the end of the running period,
//    then the prescaler restarts from zero, so the first new period
//    is a whole one. No period is ever shorter than the shorter of the
//    old and the new one, which is what keeps the switch glitch free.
//    Hazard: reserved codes would leave the mask undefined, so they
//    are refused rather than clamped.
//
// How it works
// - One enable drives core, flash, I/O, converter
// - Switch only at divided-period boundary, no glitch
// - Free-running prescaler counter, never readable
// - New factor active within old plus two new
// - Trim bit 7 always reads zero
// - Trim value drives oscillator tune output monotonically
// - Factory calibration loaded into trim on reset
// - Unlock set only when bits 6:0 zero
// - Unlock clears after four cycles or select write
// - Rewriting unlock neither restarts nor clears window
// - Divide control bits 6:4 read zero
// - Select n gives factor two to the n
// - Select writable only inside unlock window
// - Fuse programmed resets select to divide by eight

`timescale 1ns/1ps
`default_nettype none

module clk_div_trim #(
   // Prescaler width; must cover the largest factor
   parameter int CNT_W = clk_div_pkg::CNT_W
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // Straps, static, from outside the clock domain
   input  wire logic        startup_div8_fuse,
   input  wire logic [6:0]  factory_trim,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Divided clock enables
   output logic             cpu_clk_en,
   output logic             flash_clk_en,
   output logic             io_clk_en,
   output logic             adc_clk_en,
   // Oscillator tune
   output logic [6:0]       oscillator_trim
);

   // Strap synchronisers
   logic        fuse_s1_r;
   logic        fuse_s2_r;
   logic [6:0]  ftrim_s1_r;
   logic [6:0]  ftrim_s2_r;
   logic        strap_done_r;
   // Register state
   logic [3:0]  divide_select_r;
   logic [3:0]  active_sel_r;
   logic [3:0]  pending_sel_r;
   logic        pending_r;
   logic [2:0]  unlock_cnt_r;
   logic [CNT_W-1:0] prescale_r;
   logic        tick_r;
   logic        ready_r;
   logic [31:0] rdata_r;
   logic        slverr_r;
   // One flop per downstream domain enable
   logic [3:0]  en_r;

   // Unlock window state, one-hot
   typedef enum logic [1:0] {
      WIN_SHUT = 2'b01,
      WIN_OPEN = 2'b10
   } win_state_t;
   win_state_t  win_r;

   localparam int CNT_W_L = CNT_W;

   // A narrower counter could not reach the factor-256 wrap
   if (CNT_W < clk_div_pkg::CNT_W) begin : g_bad_width
      $error("CNT_W too small for the largest division factor");
   end

   // Prescaler mask for a select code: factor 2**n means wrap at 2**n-1
   function automatic logic [CNT_W_L-1:0] div_mask(input logic [3:0] s);
      logic [CNT_W_L:0] one_hot;
      one_hot = '0;
      one_hot[s] = 1'b1;
      div_mask = CNT_W_L'(one_hot - 1'b1);
   endfunction

   // Bus decode
   wire         access   = psel & penable & ~ready_r;
   // Completion edge: pready is up, so the master samples it now
   wire         done     = psel & penable & ready_r;
   wire         wr       = done & pwrite;
   wire         hit_trim = paddr == clk_div_pkg::TRIM_OFFSET;
   wire         hit_div  = paddr == clk_div_pkg::DIVCTRL_OFFSET;
   wire         hit_stat = paddr == clk_div_pkg::DIVSTAT_OFFSET;
   wire         mapped   = hit_trim | hit_div | hit_stat;
   wire         wr_div   = wr & hit_div;
   wire [3:0]   wsel     = pwdata[clk_div_pkg::SEL_LSB +: clk_div_pkg::SEL_W];
   wire         wunlock  = pwdata[clk_div_pkg::UNLOCK_BIT];
   wire         sel_ok   = wsel <= clk_div_pkg::SEL_MAX;
   // Only a pure unlock pattern opens the window
   wire         unlock_wr = wr_div & wunlock & (pwdata[6:0] == 7'h00);
   // Select written with unlock bit zero, window open
   wire         unlock_open = win_r == WIN_OPEN;
   wire         sel_wr   = wr_div & ~wunlock & unlock_open;
   // Divided-period boundary: counter at its wrap for current factor
   wire         wrap     = (prescale_r & div_mask(active_sel_r))
                           == div_mask(active_sel_r);
   // Last cycle of the old period with a new factor waiting
   wire         switch_now = strap_done_r & pending_r & wrap;

   // Synchronise straps; two flops before anything reads them. No reset
   // here: a reset stage would hide the straps at the load edge
   always_ff @(posedge core_clk) begin
      fuse_s1_r  <= startup_div8_fuse;
      fuse_s2_r  <= fuse_s1_r;
      ftrim_s1_r <= factory_trim;
      ftrim_s2_r <= ftrim_s1_r;
   end

   // Free-running synchronous prescaler on the undivided clock; no read path
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prescale_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_r <= wrap & strap_done_r;
         // Restart at load and at a switch so the new period is whole
         if (!strap_done_r || switch_now)
            prescale_r <= '0;
         else
            prescale_r <= prescale_r + 1'b1;
      end
   end

   // Unlock window counts divided-clock cycles, not master cycles, so
   // software running on the divided clock always gets four of its own
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         win_r        <= WIN_SHUT;
         unlock_cnt_r <= 3'h0;
      end else begin
         case (win_r)
            WIN_SHUT: begin
               if (unlock_wr) begin
                  win_r        <= WIN_OPEN;
                  unlock_cnt_r <= clk_div_pkg::UNLOCK_CYCLES;
               end
            end
            WIN_OPEN: begin
               if (sel_wr) begin
                  win_r        <= WIN_SHUT;
                  unlock_cnt_r <= 3'h0;
               end else if (tick_r) begin
                  // A repeated unlock write lands here and changes nothing
                  unlock_cnt_r <= unlock_cnt_r - 3'h1;
                  if (unlock_cnt_r == 3'h1)
                     win_r <= WIN_SHUT;
               end
            end
            default: begin
               win_r        <= WIN_SHUT;
               unlock_cnt_r <= 3'h0;
            end
         endcase
      end
   end

   // Select register, strap load once after reset release
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_done_r    <= 1'b0;
         divide_select_r <= clk_div_pkg::SEL_DIV1;
         oscillator_trim <= clk_div_pkg::TRIM_RST;
      end else if (!strap_done_r) begin
         strap_done_r    <= 1'b1;
         divide_select_r <= fuse_s2_r ? clk_div_pkg::SEL_DIV8
                                      : clk_div_pkg::SEL_DIV1;
         oscillator_trim <= ftrim_s2_r;
      end else begin
         // Reserved codes are refused so the divider never stalls
         if (sel_wr && sel_ok)
            divide_select_r <= wsel;
         // Trim drives the oscillator directly, higher code is faster
         if (wr && hit_trim)
            oscillator_trim <= pwdata[clk_div_pkg::TRIM_W-1:0];
      end
   end

   // Apply a new factor only at the boundary of the current period, so
   // no period is shorter than the shorter of the old and new periods
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_sel_r  <= clk_div_pkg::SEL_DIV1;
         pending_sel_r <= clk_div_pkg::SEL_DIV1;
         pending_r     <= 1'b0;
      end else if (!strap_done_r) begin
         active_sel_r  <= fuse_s2_r ? clk_div_pkg::SEL_DIV8
                                    : clk_div_pkg::SEL_DIV1;
      end else begin
         if (divide_select_r != active_sel_r && !pending_r) begin
            pending_r     <= 1'b1;
            pending_sel_r <= divide_select_r;
         end else if (pending_r && wrap) begin
            active_sel_r  <= pending_sel_r;
            pending_r     <= 1'b0;
         end
      end
   end

   // One shared enable for every synchronous domain; a flop per domain
   // keeps the fan-out local while all four stay in step
   for (genvar g = 0; g < 4; g++) begin : g_en
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst)
            en_r[g] <= 1'b0;
         else
            en_r[g] <= wrap & strap_done_r;
      end
   end

   // Domain enables, each straight from its flop
   assign cpu_clk_en   = en_r[0];
   assign flash_clk_en = en_r[1];
   assign io_clk_en    = en_r[2];
   assign adc_clk_en   = en_r[3];

   // Read mux; reserved bits read zero
   wire [31:0] rd_mux =
      hit_trim ? {24'h0, 1'b0, oscillator_trim} :
      hit_div  ? {24'h0, unlock_open, 3'b000,
                  divide_select_r} :
      hit_stat ? {27'h0, pending_r, active_sel_r} :
                 clk_div_pkg::UNMAPPED_RDATA;

   // APB answer one cycle into the access phase
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_r  <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end else begin
         ready_r  <= access;
         slverr_r <= access & ~mapped;
         if (access && !pwrite)
            rdata_r <= rd_mux;
      end
   end

   assign pready  = ready_r;
   assign pslverr = slverr_r;
   assign prdata  = rdata_r;

endmodule : clk_div_trim

`default_nettype wire

/* sim/clk_div_trim_asserts.sv */
// Purpose: Port assertions for the clock divider and trim block
// Assumes: One clock domain, reset active high
// Notes:   Bound to the design at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module clk_div_trim_asserts (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        sys_rst,
   // Strap
   input wire logic [6:0]  factory_trim,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // Enables and tune
   input wire logic        cpu_clk_en,
   input wire logic        flash_clk_en,
   input wire logic        io_clk_en,
   input wire logic        adc_clk_en,
   input wire logic [6:0]  oscillator_trim
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Read completion; read data is only meaningful here
   wire rd_done = pready & ~pwrite;
   wire mapped  = paddr inside {12'h000, 12'h004, 12'h008};
   property p_en_same;
      cpu_clk_en == flash_clk_en && io_clk_en == adc_clk_en
         && cpu_clk_en == io_clk_en;
   endproperty
   a_en_same: assert property (p_en_same)
      else $error("divided enables differ");
   property p_trim_rd;
      rd_done && paddr == 12'h000 |-> prdata[31:7] == 25'h0;
   endproperty
   a_trim_rd: assert property (p_trim_rd)
      else $error("trim upper bits not zero");
   property p_ctrl_rd;
      rd_done && paddr == 12'h004 |-> prdata[6:4] == 3'h0;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("control reserved bits not zero");
   property p_trim_wr;
      pready && pwrite && paddr == 12'h000 |=>
         {25'h0, oscillator_trim} == ($past(pwdata) & 32'h7f);
   endproperty
   a_trim_wr: assert property (p_trim_wr)
      else $error("trim output not written value");
   property p_trim_load;
      $fell(sys_rst) |-> ##[1:2] oscillator_trim == factory_trim;
   endproperty
   a_trim_load: assert property (p_trim_load)
      else $error("calibration not loaded");
   // One wait state, then a single-cycle answer
   property p_ready_wait;
      $rose(penable) && psel |=> pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait)
      else $error("pready late");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready longer than one cycle");
   property p_err;
      (pready || pslverr) |-> pready && (pslverr == !mapped);
   endproperty
   a_err: assert property (p_err)
      else $error("pslverr wrong");
endmodule // clk_div_trim_asserts
bind clk_div_trim clk_div_trim_asserts clk_div_trim_asserts_inst (
   .core_clk, .sys_rst, .factory_trim, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pready, .pslverr, .prdata, .cpu_clk_en, .flash_clk_en,
   .io_clk_en, .adc_clk_en, .oscillator_trim);
`default_nettype wire

/* sim/clk_div_trim_tb_top.sv */
// Purpose: Self-checking bench for the clock divider and trim block
// Assumes: APB calls start just after a rising edge
// Notes:   Enable periods are counted at falling edges
`timescale 1ns/1ps
`default_nettype none
module clk_div_trim_tb_top;
   logic        core_clk = 1'b0;
   logic        sys_rst  = 1'b1;
   logic        fuse     = 1'b1;
   logic [6:0]  ftrim    = 7'h15;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0;
   logic        pready, pslverr, cpu_en, ev;
   logic [31:0] prdata, rv;
   logic [6:0]  trim;
   int          n_errors = 0;
   int          cmp_count = 0;
   always #2 core_clk = ~core_clk;
   clk_div_trim clk_div_trim_inst (.core_clk, .sys_rst,
      .startup_div8_fuse(fuse), .factory_trim(ftrim), .psel, .penable,
      .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .cpu_clk_en(cpu_en), .flash_clk_en(), .io_clk_en(), .adc_clk_en(),
      .oscillator_trim(trim));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d compares=%0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tmo(input int i);
      if (i >= 600) begin
         n_errors++;
         print_verdict;
      end
   endtask
   // Keeps psel up at the end so a second call runs back to back
   task automatic apb(input logic w, input logic [11:0] a, input int d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      i = 0;
      do begin @(posedge core_clk); i++; end
      while (pready !== 1'b1 && i < 600);
      tmo(i);
      rv = prdata;
      ev = pslverr;
      penable <= 1'b0;
   endtask
   task automatic rel;
      psel <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [11:0] a, input int d);
      apb(1'b1, a, d);
      rel;
   endtask
   task automatic rd(input logic [11:0] a, input int exp);
      apb(1'b0, a, 0);
      rel;
      chk(rv, exp);
   endtask
   // Skips pulses that may still belong to the old setting
   task automatic per(input int exp);
      int i;
      repeat (3) begin
         i = 0;
         do begin @(negedge core_clk); i++; end
         while (cpu_en !== 1'b1 && i < 600);
         tmo(i);
      end
      chk(i, exp);
      @(posedge core_clk);
   endtask
   task automatic rst_run(input logic f, input logic [6:0] t);
      sys_rst <= 1'b1;
      fuse <= f;
      ftrim <= t;
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   initial #390000 tmo(600);
   initial begin
      rst_run(1'b1, 7'h15);
      rd(12'h000, 32'h15);
      rd(12'h004, 32'h03);
      per(8);
      // Trim rises in small steps; no memory writes run meanwhile
      for (int t = 32'h35; t <= 32'h75; t += 32'h20)
         wr(12'h000, t);
      wr(12'h000, 32'hff);
      rd(12'h000, 32'h7f);
      chk(trim, 7'h7f);
      wr(12'h004, 32'h02);
      rd(12'h004, 32'h03);
      wr(12'h004, 32'h81);
      wr(12'h004, 32'h02);
      rd(12'h004, 32'h03);
      // Unlock and select back to back, nothing in between
      for (int n = 0; n <= 8; n++) begin
         apb(1'b1, 12'h004, 32'h80);
         apb(1'b1, 12'h004, n);
         rel;
         rd(12'h004, n);
         per(1 << n);
      end
      rd(12'h008, 32'h08);
      chk(ev, 1'b0);
      wr(12'h004, 32'h80);
      repeat (1100) @(posedge core_clk);
      wr(12'h004, 32'h01);
      rd(12'h004, 32'h08);
      apb(1'b1, 12'h004, 32'h80);
      apb(1'b1, 12'h004, 32'h09);
      rel;
      rd(12'h004, 32'h08);
      apb(1'b1, 12'h004, 32'h80);
      apb(1'b1, 12'h004, 32'h80);
      apb(1'b1, 12'h004, 32'h02);
      rel;
      rd(12'h004, 32'h02);
      rd(12'h00c, 32'h0);
      chk(ev, 1'b1);
      rst_run(1'b0, 7'h2a);
      rd(12'h000, 32'h2a);
      rd(12'h004, 32'h00);
      per(1);
      print_verdict;
   end
endmodule // clk_div_trim_tb_top
`default_nettype wire
